// File: hdl/i2c_target_pkg.sv
package i2c_target_pkg;

  localparam logic [7:0] CTRL_A_OFS     = 8'h09;
  localparam logic [7:0] CTRL_B_OFS     = 8'h0A;
  localparam logic [7:0] STATUS_OFS     = 8'h0B;
  localparam logic [7:0] OWN_ADDR_OFS   = 8'h0C;
  localparam logic [7:0] SHIFT_DATA_OFS = 8'h0D;

  localparam int CA_ENABLE_BIT  = 0;
  localparam int CA_AUTO_BIT    = 1;
  localparam int CA_STOP_EN_BIT = 5;
  localparam int CB_ACK_BIT     = 2;
  localparam int ST_DONE_BIT    = 7;
  localparam int ST_ADDR_BIT    = 6;
  localparam int ST_DRIVE_CONFLICT_FLAG_BIT    = 3;

  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  typedef enum logic [1:0] {
    CMD_NO_OPERATION      = 2'h0,
    CMD_RESERVED          = 2'h1,
    CMD_COMPLETE_TRANSFER = 2'h2,
    CMD_RESPONSE          = 2'h3
  } target_command_t;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'h0,
    ST_ADDR       = 3'h1,
    ST_WAIT_ADDR  = 3'h2,
    ST_ACK        = 3'h3,
    ST_RX         = 3'h4,
    ST_WAIT_DATA  = 3'h5,
    ST_TX         = 3'h6,
    ST_MASTER_ACK = 3'h7
  } target_state_t;

  typedef enum logic [1:0] {
    AFTER_IDLE       = 2'h0,
    AFTER_RX         = 2'h1,
    AFTER_DATA_EVENT = 2'h2
  } after_ack_t;

  typedef struct packed {
    logic byte_done_flag;
    logic addr_or_stop_flag;
    logic scl_stretch_active;
    logic master_ack_received;
    logic drive_conflict_flag;
    logic illegal_condition_flag;
    logic master_reads;
    logic event_cause;
  } target_status_t;

endpackage : i2c_target_pkg

// File: hdl/i2c_target_command_status.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module i2c_target_command_status
  import i2c_target_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n
);

  function automatic logic sticky(input logic set, input logic clr, input logic cur);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  logic            scl_s1_r, scl_s2_r, scl_d_r;
  logic            sda_s1_r, sda_s2_r, sda_d_r;
  target_state_t   state_r, state_nxt;
  after_ack_t      after_r, after_nxt;
  logic      [3:0] cnt_r, cnt_nxt;
  logic      [7:0] shreg_r, shreg_nxt;
  logic            hold_r, hold_nxt;
  logic            drive_nxt;
  logic            sda_oe_n_r, scl_oe_n_r;
  logic            dif_r, addr_or_stop_flag_r, drive_conflict_flag_r, master_ack_received_r, master_ack_received_nxt;
  logic            dir_r, dir_nxt, cause_r;
  logic            ack_sel_r, enable_r, auto_r, stop_en_r;
  logic      [6:0] own_addr_r;
  logic      [7:0] rdata_r;
  logic            set_dif, set_addr, set_stop, set_drive_conflict_flag;

  // Bus conditions from the synchronised lines.
  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire start    = enable_r & scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire stop     = enable_r & scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  wire wr_ca = wr & (addr == CTRL_A_OFS);
  wire wr_cb = wr & (addr == CTRL_B_OFS);
  wire wr_st = wr & (addr == STATUS_OFS);
  wire wr_oa = wr & (addr == OWN_ADDR_OFS);
  wire wr_sd = wr & (addr == SHIFT_DATA_OFS);
  wire rd_sd = rd & (addr == SHIFT_DATA_OFS);
  wire data_access = wr_sd | rd_sd;

  wire target_command_t cmd_w = wr_cb ? target_command_t'(wdata[1:0]) : CMD_NO_OPERATION;
  wire waiting   = (state_r == ST_WAIT_ADDR) | (state_r == ST_WAIT_DATA);
  wire valid_cmd = (cmd_w == CMD_COMPLETE_TRANSFER) | (cmd_w == CMD_RESPONSE);
  wire go_resp   = waiting & ((cmd_w == CMD_RESPONSE) | (auto_r & data_access));
  wire go_comp   = waiting & (cmd_w == CMD_COMPLETE_TRANSFER);
  wire ack_eff   = wr_cb ? wdata[CB_ACK_BIT] : ack_sel_r;
  wire tx_msb    = wr_sd ? wdata[7] : shreg_r[7];
  wire addr_hit  = (shreg_r[7:1] == own_addr_r);
  wire sw_clear  = waiting & wr_st & (wdata[ST_DONE_BIT] | wdata[ST_ADDR_BIT]);
  wire want_high = ((state_r == ST_ACK) | (state_r == ST_TX)) & sda_oe_n_r;

  wire clr_dif  = (wr_st & wdata[ST_DONE_BIT]) | data_access | valid_cmd;
  wire clr_addr_or_stop_flag = (wr_st & wdata[ST_ADDR_BIT]) | data_access | valid_cmd;
  wire clr_drive_conflict_flag = (wr_st & wdata[ST_DRIVE_CONFLICT_FLAG_BIT]) | start;

  wire dif_nxt   = sticky(set_dif, clr_dif, dif_r);
  wire addr_or_stop_flag_nxt  = sticky(set_addr | set_stop, clr_addr_or_stop_flag, addr_or_stop_flag_r);
  wire drive_conflict_flag_nxt  = sticky(set_drive_conflict_flag, clr_drive_conflict_flag, drive_conflict_flag_r);
  wire cause_nxt = set_addr ? 1'b1 : (set_stop ? 1'b0 : cause_r);

  wire target_status_t status_w = '{byte_done_flag:         dif_r,
                                    addr_or_stop_flag:      addr_or_stop_flag_r,
                                    scl_stretch_active:     hold_r,
                                    master_ack_received:    master_ack_received_r,
                                    drive_conflict_flag:    drive_conflict_flag_r,
                                    illegal_condition_flag: 1'b0,
                                    master_reads:           dir_r,
                                    event_cause:            cause_r};

  wire [7:0] ctrl_a_w = {2'b00, stop_en_r, 3'b000, auto_r, enable_r};
  wire [7:0] ctrl_b_w = {5'b00000, ack_sel_r, 2'b00};
  wire [7:0] rd_sel   = (addr == CTRL_A_OFS)     ? ctrl_a_w :
                        (addr == CTRL_B_OFS)     ? ctrl_b_w :
                        (addr == STATUS_OFS)     ? status_w :
                        (addr == OWN_ADDR_OFS)   ? {own_addr_r, 1'b0} :
                        (addr == SHIFT_DATA_OFS) ? shreg_r : REG_RESET;

  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = (wr_sd & hold_r) ? wdata : shreg_r;
    hold_nxt  = hold_r;
    drive_nxt = ~sda_oe_n_r;
    master_ack_received_nxt = master_ack_received_r;
    dir_nxt   = dir_r;
    set_dif   = 1'b0;
    set_addr  = 1'b0;
    set_stop  = 1'b0;
    set_drive_conflict_flag  = scl_rise & want_high & ~sda_s2_r;
    case (state_r)
      ST_IDLE: begin
      end
      ST_ADDR, ST_RX: begin
        if (scl_rise) begin
          shreg_nxt = {shreg_r[6:0], sda_s2_r};
          cnt_nxt   = cnt_r + 4'h1;
        end
        if (scl_fall && cnt_r == BITS_PER_BYTE) begin
          cnt_nxt = 4'h0;
          if (state_r == ST_RX) begin
            set_dif   = 1'b1;
            hold_nxt  = 1'b1;
            state_nxt = ST_WAIT_DATA;
          end else if (addr_hit) begin
            set_addr  = 1'b1;
            dir_nxt   = shreg_r[0];
            hold_nxt  = 1'b1;
            state_nxt = ST_WAIT_ADDR;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_WAIT_ADDR, ST_WAIT_DATA: begin
        if (go_resp) begin
          hold_nxt = 1'b0;
          if (state_r == ST_WAIT_DATA && dir_r) begin
            drive_nxt = ~tx_msb;
            cnt_nxt   = 4'h0;
            state_nxt = ST_TX;
          end else begin
            drive_nxt = ~ack_eff;
            after_nxt = (dir_r && state_r == ST_WAIT_ADDR) ? AFTER_DATA_EVENT : AFTER_RX;
            state_nxt = ST_ACK;
          end
        end else if (go_comp) begin
          hold_nxt = 1'b0;
          if (dir_r) begin
            state_nxt = ST_IDLE;
          end else begin
            drive_nxt = ~ack_eff;
            after_nxt = AFTER_IDLE;
            state_nxt = ST_ACK;
          end
        end else if (sw_clear) begin
          hold_nxt  = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          drive_nxt = 1'b0;
          cnt_nxt   = 4'h0;
          case (after_r)
            AFTER_RX: begin
              state_nxt = ST_RX;
            end
            AFTER_DATA_EVENT: begin
              set_dif   = 1'b1;
              hold_nxt  = 1'b1;
              state_nxt = ST_WAIT_DATA;
            end
            default: begin
              state_nxt = ST_IDLE;
            end
          endcase
        end
      end
      ST_TX: begin
        if (scl_rise) begin
          cnt_nxt = cnt_r + 4'h1;
        end
        if (scl_fall) begin
          if (cnt_r == BITS_PER_BYTE) begin
            drive_nxt = 1'b0;
            state_nxt = ST_MASTER_ACK;
          end else begin
            shreg_nxt = {shreg_r[6:0], 1'b0};
            drive_nxt = ~shreg_r[6];
          end
        end
      end
      ST_MASTER_ACK: begin
        if (scl_rise) begin
          master_ack_received_nxt = sda_s2_r;
        end
        if (scl_fall) begin
          set_dif   = 1'b1;
          hold_nxt  = 1'b1;
          state_nxt = ST_WAIT_DATA;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (start) begin
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
      hold_nxt  = 1'b0;
    end else if (stop) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      hold_nxt  = 1'b0;
      set_stop  = stop_en_r;
    end
    if (!enable_r) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
      hold_nxt  = 1'b0;
      set_dif   = 1'b0;
      set_addr  = 1'b0;
      set_drive_conflict_flag  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    scl_s1_r <= scl_i;
    scl_s2_r <= scl_s1_r;
    scl_d_r  <= scl_s2_r;
    sda_s1_r <= sda_i;
    sda_s2_r <= sda_s1_r;
    sda_d_r  <= sda_s2_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      after_r    <= AFTER_IDLE;
      cnt_r      <= 4'h0;
      shreg_r    <= REG_RESET;
      hold_r     <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      master_ack_received_r    <= 1'b0;
      dir_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      after_r    <= after_nxt;
      cnt_r      <= cnt_nxt;
      shreg_r    <= shreg_nxt;
      hold_r     <= hold_nxt;
      scl_oe_n_r <= ~hold_nxt;
      sda_oe_n_r <= ~(drive_nxt & ~drive_conflict_flag_r & ~set_drive_conflict_flag);
      master_ack_received_r    <= master_ack_received_nxt;
      dir_r      <= dir_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dif_r   <= 1'b0;
      addr_or_stop_flag_r  <= 1'b0;
      drive_conflict_flag_r  <= 1'b0;
      cause_r <= 1'b0;
      rdata_r <= REG_RESET;
    end else begin
      dif_r   <= dif_nxt;
      addr_or_stop_flag_r  <= addr_or_stop_flag_nxt;
      drive_conflict_flag_r  <= drive_conflict_flag_nxt;
      cause_r <= cause_nxt;
      rdata_r <= rd ? rd_sel : REG_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r   <= 1'b0;
      auto_r     <= 1'b0;
      stop_en_r  <= 1'b0;
      ack_sel_r  <= 1'b0;
      own_addr_r <= OWN_ADDR_RESET;
    end else begin
      if (wr_ca) begin
        enable_r  <= wdata[CA_ENABLE_BIT];
        auto_r    <= wdata[CA_AUTO_BIT];
        stop_en_r <= wdata[CA_STOP_EN_BIT];
      end
      if (wr_cb) begin
        ack_sel_r <= wdata[CB_ACK_BIT];
      end
      if (wr_oa) begin
        own_addr_r <= wdata[7:1];
      end
    end
  end

  assign rdata    = rdata_r;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;

  wire quiet = enable_r & ~start & ~stop;

  sequence s_ctrl_b_read;
    rd && (addr == CTRL_B_OFS);
  endsequence
  property p_cmd_reads_zero;
    @(posedge clk) disable iff (rst) s_ctrl_b_read |=> (rdata[1:0] == 2'b00) && (rdata[2] == $past(ack_sel_r));
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command field read nonzero");

  property p_ack_sel_stable;
    @(posedge clk) disable iff (rst) !wr_cb |=> $stable(ack_sel_r);
  endproperty
  a_ack_sel_stable: assert property (p_ack_sel_stable) else $error("ack select changed");

  property p_event_holds_scl;
    @(posedge clk) disable iff (rst) (set_dif || set_addr) |=> hold_r && !scl_oe_n && status_w[5];
  endproperty
  a_event_holds_scl: assert property (p_event_holds_scl) else $error("event without hold");

  property p_stall_without_auto;
    @(posedge clk) disable iff (rst) (waiting && hold_r && !auto_r && data_access && quiet) |=> hold_r && waiting;
  endproperty
  a_stall_without_auto: assert property (p_stall_without_auto) else $error("data access resumed");

  property p_complete_read_no_ack;
    @(posedge clk) disable iff (rst) (go_comp && dir_r && quiet) |=> (state_r == ST_IDLE) && sda_oe_n;
  endproperty
  a_complete_read_no_ack: assert property (p_complete_read_no_ack) else $error("ack driven on read");

  property p_drive_conflict_flag_no_drive;
    @(posedge clk) disable iff (rst) drive_conflict_flag_r |-> sda_oe_n;
  endproperty
  a_drive_conflict_flag_no_drive: assert property (p_drive_conflict_flag_no_drive) else $error("sda driven in collision");

  property p_start_clears_drive_conflict_flag;
    @(posedge clk) disable iff (rst) (start && !set_drive_conflict_flag) |=> !drive_conflict_flag_r;
  endproperty
  a_start_clears_drive_conflict_flag: assert property (p_start_clears_drive_conflict_flag) else $error("collision kept over start");

  property p_disabled_idle;
    @(posedge clk) disable iff (rst) !enable_r |=> (state_r == ST_IDLE) && scl_oe_n && sda_oe_n;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled target active");

  property p_cmd_clears_done;
    @(posedge clk) disable iff (rst) (dif_r && valid_cmd && !set_dif) |=> !dif_r;
  endproperty
  a_cmd_clears_done: assert property (p_cmd_clears_done) else $error("byte done not cleared");

  property p_null_cmd_no_effect;
    @(posedge clk) disable iff (rst) (waiting && wr_cb && !wdata[1] && quiet && !set_dif && !set_addr)
      |=> $stable(hold_r) && $stable(state_r) && $stable(dif_r) && $stable(addr_or_stop_flag_r);
  endproperty
  a_null_cmd_no_effect: assert property (p_null_cmd_no_effect) else $error("null command acted");

  sequence s_addr_read_ack_end;
    (state_r == ST_ACK) && (after_r == AFTER_DATA_EVENT) && scl_fall && quiet;
  endsequence
  property p_read_addr_raises_done;
    @(posedge clk) disable iff (rst) s_addr_read_ack_end |=> dif_r && hold_r && (state_r == ST_WAIT_DATA);
  endproperty
  a_read_addr_raises_done: assert property (p_read_addr_raises_done) else $error("no data event");

  property p_new_ack_used;
    @(posedge clk) disable iff (rst) ((state_r == ST_WAIT_ADDR) && wr_cb && (wdata[1:0] == 2'h3) && !wdata[2]
      && !drive_conflict_flag_r && !set_drive_conflict_flag && quiet) |=> !sda_oe_n && (state_r == ST_ACK);
  endproperty
  a_new_ack_used: assert property (p_new_ack_used) else $error("new ack value not used");

  property p_stop_cause;
    @(posedge clk) disable iff (rst) set_stop |=> addr_or_stop_flag_r && !cause_r;
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop cause wrong");

endmodule : i2c_target_command_status

// File: bench/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe_n,
  output logic      sda_oe_n
);
  localparam realtime HALF = 62.5;

  logic       busy;
  logic       hung;
  logic       got_ack;
  logic [7:0] got_byte;

  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
    busy     = 1'b0;
    hung     = 1'b0;
    got_ack  = 1'b0;
    got_byte = 8'h00;
  end

  // Honours clock stretching: the high phase only starts once the wire is really high.
  task automatic release_scl;
    int n;
    n = 0;
    scl_oe_n = 1'b1;
    while (scl !== 1'b1 && n < 200000) begin
      #1;
      n++;
    end
    if (scl !== 1'b1) begin
      hung = 1'b1;
    end
  endtask : release_scl

  // Data changes well after the falling edge so it is never mistaken for a start or stop.
  task automatic clock_bit(input logic v, output logic s);
    #20;
    sda_oe_n = v;
    #(HALF - 20.0);
    release_scl();
    #HALF;
    s = sda;
    scl_oe_n = 1'b0;
  endtask : clock_bit

  task automatic start;
    busy = 1'b1;
    #20;
    sda_oe_n = 1'b1;
    #HALF;
    release_scl();
    #HALF;
    sda_oe_n = 1'b0;
    #HALF;
    scl_oe_n = 1'b0;
    busy = 1'b0;
  endtask : start

  task automatic stop;
    busy = 1'b1;
    #20;
    sda_oe_n = 1'b0;
    #HALF;
    release_scl();
    #HALF;
    sda_oe_n = 1'b1;
    #HALF;
    busy = 1'b0;
  endtask : stop

  // Pulling SDA low in the acknowledge slot is the commanded fault for the collision case.
  task automatic wbyte(input logic [7:0] b, input logic ack_low);
    logic s;
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(~ack_low, got_ack);
    busy = 1'b0;
  endtask : wbyte

  task automatic rbyte(input logic nack);
    logic s;
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      got_byte[i] = s;
    end
    clock_bit(nack, s);
    busy = 1'b0;
  endtask : rbyte
endmodule : i2c_master_model

// File: bench/i2c_target_command_status_bench.sv
`timescale 1ns/1ps
module i2c_target_command_status_bench;
  import i2c_target_pkg::*;

  localparam logic [6:0] OWN_ADDR = 7'h5A;

  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       scl_o;
  logic       scl_oe_n;
  logic       sda_o;
  logic       sda_oe_n;
  logic       m_scl_oe_n;
  logic       m_sda_oe_n;
  logic [7:0] d;
  logic [7:0] dut_map [5];
  int         bad_count;
  int         n_compared;
  wire        scl_line = scl_oe_n & m_scl_oe_n;
  wire        sda_line = sda_oe_n & m_sda_oe_n;

  i2c_target_command_status dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
  );

  i2c_master_model u_m (
    .scl(scl_line), .sda(sda_line), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n)
  );

  always #5 clk = ~clk;

  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  task automatic wait_hold;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    rd_reg(STATUS_OFS, d);
    while (d[5] !== 1'b1 && n < 600) begin
      rd_reg(STATUS_OFS, d);
      n++;
    end
    if (d[5] !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_hold

  task automatic wait_master;
    int n;
    n = 0;
    @(posedge clk);
    while (u_m.busy && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (u_m.busy) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_master

  always @(posedge u_m.hung) begin
    bad_count++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (dut_map[i]) begin
      rd_reg(dut_map[i], d);
      check(d, REG_RESET);
    end
    wr_reg(CTRL_B_OFS, 8'h04);
    rd_reg(CTRL_B_OFS, d);
    check(d, 8'h04);
    wr_reg(OWN_ADDR_OFS, {OWN_ADDR, 1'b0});
    // Target still disabled: the address must go unanswered.
    u_m.start();
    u_m.wbyte({OWN_ADDR, 1'b0}, 1'b0);
    check({7'h00, u_m.got_ack}, 8'h01);
    rd_reg(STATUS_OFS, d);
    check(d, 8'h00);
    u_m.stop();
    // Master write, stalling mode, no stop event.
    wr_reg(CTRL_A_OFS, 8'h01);
    wr_reg(CTRL_B_OFS, 8'h00);
    fork
      begin
        u_m.start();
        u_m.wbyte({OWN_ADDR, 1'b0}, 1'b0);
        u_m.wbyte(8'hA5, 1'b0);
      end
    join_none
    wait_hold();
    check(d, 8'h61);
    wr_reg(CTRL_B_OFS, 8'h03);
    wait_hold();
    check(d & 8'hFE, 8'hA0);
    check({7'h00, u_m.got_ack}, 8'h00);
    rd_reg(SHIFT_DATA_OFS, d);
    check(d, 8'hA5);
    repeat (20) @(posedge clk);
    rd_reg(STATUS_OFS, d);
    check(d & 8'hE0, 8'h20);
    wr_reg(CTRL_B_OFS, 8'h06);
    wait_master();
    check({7'h00, u_m.got_ack}, 8'h01);
    u_m.stop();
    rd_reg(STATUS_OFS, d);
    check(d & 8'hE0, 8'h00);
    // Master read, auto-continue, stop event enabled.
    wr_reg(CTRL_A_OFS, 8'h23);
    wr_reg(CTRL_B_OFS, 8'h00);
    fork
      begin
        u_m.start();
        u_m.wbyte({OWN_ADDR, 1'b1}, 1'b0);
        u_m.rbyte(1'b1);
      end
    join_none
    wait_hold();
    check(d, 8'h63);
    wr_reg(CTRL_B_OFS, 8'h00);
    repeat (20) @(posedge clk);
    rd_reg(STATUS_OFS, d);
    check(d, 8'h63);
    wr_reg(SHIFT_DATA_OFS, 8'h00);
    wait_hold();
    check(d & 8'hFE, 8'hA2);
    wr_reg(SHIFT_DATA_OFS, 8'h3C);
    wait_hold();
    check(d & 8'hFE, 8'hB2);
    check(u_m.got_byte, 8'h3C);
    wr_reg(CTRL_B_OFS, 8'h02);
    wait_master();
    u_m.stop();
    rd_reg(STATUS_OFS, d);
    check(d, 8'h52);
    wr_reg(STATUS_OFS, 8'h40);
    rd_reg(STATUS_OFS, d);
    check(d & 8'hE0, 8'h00);
    // Collision: master pulls SDA low while the target answers NACK.
    wr_reg(CTRL_A_OFS, 8'h01);
    fork
      begin
        u_m.start();
        u_m.wbyte({OWN_ADDR, 1'b0}, 1'b1);
      end
    join_none
    wait_hold();
    wr_reg(CTRL_B_OFS, 8'h07);
    wait_master();
    rd_reg(STATUS_OFS, d);
    check(d & 8'h08, 8'h08);
    u_m.start();
    repeat (10) @(posedge clk);
    rd_reg(STATUS_OFS, d);
    check(d & 8'h08, 8'h00);
    u_m.stop();
    check({6'h00, scl_o, sda_o}, 8'h00);
    report_and_stop();
  end

  initial begin
    dut_map = '{CTRL_A_OFS, CTRL_B_OFS, STATUS_OFS, OWN_ADDR_OFS, 8'h0F};
  end
endmodule : i2c_target_command_status_bench
